//--- logic/shared_pin_io_defs.svh
`ifndef SHARED_PIN_IO_DEFS_SVH
`define SHARED_PIN_IO_DEFS_SVH

`define PORT_WIDTH 16
`define CHANGE_PIN_COUNT 21
`define CHANGE_LO_WIDTH 16
`define DIRECTION_RESET 16'hffff
`define LATCH_RESET 16'h0000
`define OPEN_DRAIN_RESET 16'h0000
`define ANALOG_CFG_RESET 16'h0000
`define CHANGE_ENABLE_RESET 16'h0000
`define PULLUP_RESET 16'h0000
`define REG_SEL_DIRECTION 3'h0
`define REG_SEL_LATCH 3'h1
`define REG_SEL_PIN_LEVEL 3'h2
`define REG_SEL_OPEN_DRAIN 3'h3
`define REG_SEL_ANALOG_CFG 3'h4
`define REG_SEL_CHANGE_LO 3'h5
`define REG_SEL_CHANGE_HI 3'h6

`endif

//--- logic/shared_pin_io_pkg.sv
package shared_pin_io_pkg;
    typedef struct packed {
        logic write;
        logic [2:0] sel;
        logic [15:0] data;
    } reg_access_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;
endpackage : shared_pin_io_pkg

//--- logic/change_notice_detect.sv
`timescale 1ns/1ps
`include "shared_pin_io_defs.svh"

module change_notice_detect
    import shared_pin_io_pkg::*;
#(
    parameter int N = `CHANGE_PIN_COUNT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [N-1:0] pin_raw,
    input wire logic [N-1:0] enable,
    input wire logic flag_clear,
    output logic flag
);
    logic [N-1:0] sync_a;
    logic [N-1:0] sync_b;
    logic [N-1:0] prev;
    logic [N-1:0] hit;

    initial begin
        if (N < 1 || N > 32) begin
            $error("change_notice_detect: N out of range");
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
            prev <= '0;
        end else begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
            prev <= sync_b;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_cmp
            assign hit[i] = enable[i] & (sync_b[i] ^ prev[i]);
        end
    endgenerate

    // Set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (|hit) begin
            flag <= 1'b1;
        end else if (flag_clear) begin
            flag <= 1'b0;
        end
    end
endmodule : change_notice_detect

//--- logic/shared_pin_io_port.sv
`timescale 1ns/1ps
`include "shared_pin_io_defs.svh"

module shared_pin_io_port
    import shared_pin_io_pkg::*;
#(
    parameter int W = `PORT_WIDTH,
    parameter logic [15:0] IMPL_MASK = 16'hffff,
    parameter logic [15:0] ANALOG_MASK = 16'h003f,
    parameter int CN = `CHANGE_PIN_COUNT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire reg_access_t reg_access,
    output logic [15:0] read_data,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    input wire logic [W-1:0] periph_enable,
    input wire logic [W-1:0] periph_drive_active,
    input wire logic [W-1:0] periph_out,
    output logic [W-1:0] periph_in,
    input wire logic [CN-1:0] change_notice_pin,
    output logic [CN-1:0] weak_pullup_on,
    input wire logic change_irq_clear,
    output logic change_irq
);
    logic [W-1:0] pin_direction_reg;
    logic [W-1:0] output_latch_reg;
    logic [W-1:0] open_drain_ctl_reg;
    logic [W-1:0] analog_pin_cfg_reg;
    logic [W-1:0] pin_level_reg;
    logic [15:0] change_irq_enable_lo;
    logic [15:0] change_irq_enable_hi;
    logic [15:0] weak_pullup_enable_lo;
    logic [15:0] weak_pullup_enable_hi;
    logic [W-1:0] impl;
    logic [W-1:0] analog_sel;
    logic [W-1:0] port_owns;
    logic [W-1:0] next_pin_out;
    logic [W-1:0] next_pin_oe;
    logic [31:0] cn_enable_all;
    logic [31:0] pullup_all;
    logic [15:0] next_read_data;
    logic [W-1:0] wdata;
    logic cn_flag;

    initial begin
        if (W < 1 || W > 16 || CN < 1 || CN > 32) begin
            $error("shared_pin_io_port: width out of range");
        end
    end

    assign impl = IMPL_MASK[W-1:0];
    assign analog_sel = ~analog_pin_cfg_reg & ANALOG_MASK[W-1:0] & impl;
    assign wdata = reg_access.data[W-1:0] & impl;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_direction_reg <= W'(`DIRECTION_RESET) & impl;
        end else if (reg_access.write &&
                     reg_access.sel == `REG_SEL_DIRECTION) begin
            pin_direction_reg <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            output_latch_reg <= W'(`LATCH_RESET);
        end else if (reg_access.write &&
                     (reg_access.sel == `REG_SEL_LATCH ||
                      reg_access.sel == `REG_SEL_PIN_LEVEL)) begin
            output_latch_reg <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            open_drain_ctl_reg <= W'(`OPEN_DRAIN_RESET);
            analog_pin_cfg_reg <= W'(`ANALOG_CFG_RESET);
        end else if (reg_access.write) begin
            if (reg_access.sel == `REG_SEL_OPEN_DRAIN) begin
                open_drain_ctl_reg <= wdata;
            end
            if (reg_access.sel == `REG_SEL_ANALOG_CFG) begin
                analog_pin_cfg_reg <= reg_access.data[W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            change_irq_enable_lo <= `CHANGE_ENABLE_RESET;
            change_irq_enable_hi <= `CHANGE_ENABLE_RESET;
            weak_pullup_enable_lo <= `PULLUP_RESET;
            weak_pullup_enable_hi <= `PULLUP_RESET;
        end else if (reg_access.write) begin
            if (reg_access.sel == `REG_SEL_CHANGE_LO) begin
                change_irq_enable_lo <= reg_access.data;
                weak_pullup_enable_lo <= weak_pullup_enable_lo;
            end
            if (reg_access.sel == `REG_SEL_CHANGE_HI) begin
                change_irq_enable_hi <= reg_access.data;
            end
        end
    end

    // Pull-up words have no write select in this build and stay at reset
    assign cn_enable_all = {change_irq_enable_hi, change_irq_enable_lo};
    assign pullup_all = {weak_pullup_enable_hi, weak_pullup_enable_lo};

    // Pin level sampled one clock after the pin, so a read sees it late
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_level_reg <= '0;
        end else begin
            pin_level_reg <= pin_in & impl & ~analog_sel;
        end
    end

    always_comb begin
        next_read_data = 16'h0000;
        unique case (reg_access.sel)
            `REG_SEL_DIRECTION: next_read_data[W-1:0] = pin_direction_reg;
            `REG_SEL_LATCH: next_read_data[W-1:0] = output_latch_reg;
            `REG_SEL_PIN_LEVEL: next_read_data[W-1:0] = pin_level_reg;
            `REG_SEL_OPEN_DRAIN: next_read_data[W-1:0] = open_drain_ctl_reg;
            `REG_SEL_ANALOG_CFG: next_read_data[W-1:0] = analog_pin_cfg_reg;
            `REG_SEL_CHANGE_LO: next_read_data = change_irq_enable_lo;
            `REG_SEL_CHANGE_HI: next_read_data = change_irq_enable_hi;
            default: next_read_data = {15'h0000, cn_flag};
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            read_data <= 16'h0000;
        end else begin
            read_data <= next_read_data;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            // Input-only peripherals never assert drive_active
            assign port_owns[i] = ~(periph_enable[i] &
                                    periph_drive_active[i]);
            always_comb begin
                if (!port_owns[i]) begin
                    next_pin_out[i] = periph_out[i];
                    next_pin_oe[i] = impl[i];
                end else if (open_drain_ctl_reg[i]) begin
                    next_pin_out[i] = 1'b0;
                    next_pin_oe[i] = ~pin_direction_reg[i] &
                                     ~output_latch_reg[i] & impl[i];
                end else begin
                    next_pin_out[i] = output_latch_reg[i];
                    next_pin_oe[i] = ~pin_direction_reg[i] & impl[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_out <= '0;
            pin_oe <= '0;
            periph_in <= '0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            // Block port output from looping into the peripheral input
            periph_in <= pin_in & ~(next_pin_oe & port_owns);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            weak_pullup_on <= '0;
        end else begin
            weak_pullup_on <= pullup_all[CN-1:0];
        end
    end

    change_notice_detect #(.N(CN)) u_cn (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_raw(change_notice_pin),
        .enable(cn_enable_all[CN-1:0]),
        .flag_clear(change_irq_clear),
        .flag(cn_flag)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            change_irq <= 1'b0;
        end else begin
            change_irq <= cn_flag;
        end
    end
endmodule : shared_pin_io_port

//--- tb/shared_pin_io_port_sva.sv
`timescale 1ns/1ps
module port_checker
    import shared_pin_io_pkg::*;
#(
    parameter int W = 16,
    parameter logic [15:0] IMPL_MASK = 16'hffff,
    parameter logic [15:0] ANALOG_MASK = 16'h003f,
    parameter int CN = 21
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire reg_access_t reg_access,
    input wire logic [15:0] read_data,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] periph_enable,
    input wire logic [W-1:0] periph_drive_active,
    input wire logic [W-1:0] periph_in,
    input wire logic [CN-1:0] change_notice_pin,
    input wire logic [CN-1:0] weak_pullup_on,
    input wire logic change_irq_clear,
    input wire logic change_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] ana;
    logic [3:0] since;
    always_ff @(posedge clk) begin
        if (sys_rst) ana <= 16'h0000;
        else if (reg_access.write && reg_access.sel == 3'h4)
            ana <= reg_access.data;
    end
    // Cycles since the last change on the notice inputs
    always_ff @(posedge clk) begin
        if (sys_rst || $changed(change_notice_pin)) since <= 4'h0;
        else if (since != 4'hf) since <= since + 4'h1;
    end
    property p_rst_in; $past(sys_rst) |-> pin_oe == '0; endproperty
    a_rst_in: assert property (p_rst_in) else $error("oe after reset");
    property p_nc_oe; (pin_oe & ~IMPL_MASK) == '0; endproperty
    a_nc_oe: assert property (p_nc_oe) else $error("unimpl oe");
    property p_nc_rd;
        $past(reg_access.sel) <= 3'h2 |-> (read_data & ~IMPL_MASK) == '0;
    endproperty
    a_nc_rd: assert property (p_nc_rd) else $error("unimpl read");
    property p_ana;
        $past(reg_access.sel) == 3'h2 |-> (read_data & ANALOG_MASK & ~ana) == '0;
    endproperty
    a_ana: assert property (p_ana) else $error("analog read");
    property p_stat;
        $past(reg_access.sel) == 3'h7 |-> read_data == {15'h0, change_irq};
    endproperty
    a_stat: assert property (p_stat) else $error("status read");
    // The request output trails the flag by one clock, so a clear shows late
    property p_hold;
        change_irq && !change_irq_clear && !$past(change_irq_clear) |=>
            change_irq;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_cause; $rose(change_irq) |-> since < 4'h8; endproperty
    a_cause: assert property (p_cause) else $error("flag no cause");
    property p_pu; weak_pullup_on == '0; endproperty
    a_pu: assert property (p_pu) else $error("pullup on");
    property p_loop;
        $stable(pin_oe) && $stable(periph_drive_active) |->
            (periph_in & pin_oe & ~(periph_enable & periph_drive_active)) == '0;
    endproperty
    a_loop: assert property (p_loop) else $error("loop through");
    cover property ($rose(change_irq));
    cover property ($past(reg_access.sel) == 3'h7 && read_data[0]);
    cover property (|(periph_enable & periph_drive_active));
endmodule : port_checker
bind shared_pin_io_port port_checker #(.W(W), .IMPL_MASK(IMPL_MASK),
    .ANALOG_MASK(ANALOG_MASK), .CN(CN)) port_checker_i (.*);

//--- tb/pin_world.sv
`timescale 1ns/1ps
module pin_world #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pin_in
);
    logic [W-1:0] last;
    // Floating pins toggle so a stale level never passes
    always_ff @(posedge clk) last <= pin_in;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & ~last);
endmodule : pin_world

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import shared_pin_io_pkg::*;
    logic clk, sys_rst, change_irq_clear, change_irq;
    reg_access_t reg_access;
    logic [15:0] read_data, pin_in, pin_out, pin_oe, ext_en, ext_val;
    logic [15:0] periph_enable, periph_drive_active, periph_out, periph_in;
    logic [20:0] change_notice_pin, weak_pullup_on;
    int fail_count = 0;
    int samples_checked = 0;
    shared_pin_io_port #(.IMPL_MASK(16'h7fff)) shared_pin_io_port_i (.clk,
        .sys_rst, .reg_access, .read_data, .pin_in, .pin_out, .pin_oe,
        .periph_enable, .periph_drive_active, .periph_out, .periph_in,
        .change_notice_pin, .weak_pullup_on, .change_irq_clear, .change_irq);
    pin_world pin_world_i (.clk, .pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(posedge clk) reg_access <= '{1'b1, s, d};
        @(posedge clk) reg_access.write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] s, input logic [15:0] e, string n);
        @(posedge clk) reg_access <= '{1'b0, s, 16'h0000};
        repeat (4) @(posedge clk);
        #1 chk(n, e, read_data);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic t_reset;
        sys_rst <= 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        settle(1);
        chk("oe", 0, pin_oe);
        rd(3'h0, 16'h7fff, "dir");
        rd(3'h1, 16'h0000, "lat");
        rd(3'h4, 16'h0000, "ana");
    endtask : t_reset
    task automatic t_latch;
        wr(3'h4, 16'hffff);
        wr(3'h0, 16'h0000);
        wr(3'h1, 16'ha5c3);
        settle(3);
        chk("oe", 16'h7fff, pin_oe);
        chk("out", 16'h25c3, pin_out);
        rd(3'h2, 16'h25c3, "pin");
        wr(3'h2, 16'h1234);
        rd(3'h1, 16'h1234, "lat");
    endtask : t_latch
    task automatic t_analog;
        wr(3'h0, 16'hffff);
        wr(3'h4, 16'h0000);
        rd(3'h2, 16'h7fc0, "pin");
        wr(3'h4, 16'hffff);
        rd(3'h2, 16'h7fff, "pin");
    endtask : t_analog
    task automatic t_od;
        wr(3'h0, 16'h0000);
        wr(3'h3, 16'h00f0);
        wr(3'h1, 16'h00a0);
        settle(3);
        chk("oe", 16'h0050, pin_oe & 16'h00f0);
        chk("hi", 0, pin_out & pin_oe & 16'h00f0);
        rd(3'h2, 16'h00a0, "pin");
        wr(3'h3, 16'h0000);
    endtask : t_od
    task automatic t_periph;
        @(posedge clk) periph_enable <= 16'h0001;
        periph_drive_active <= 16'h0001;
        periph_out <= 16'h0001;
        settle(3);
        chk("out", 1, pin_out[0]);
        rd(3'h2, 16'h00a1, "pin");
        @(posedge clk) periph_drive_active <= 16'h0000;
        settle(3);
        chk("own", 1, {pin_oe[0], pin_out[0]} == 2'b10);
        chk("loop", 0, periph_in[0]);
    endtask : t_periph
    task automatic t_change;
        wr(3'h5, 16'h0008);
        wr(3'h6, 16'h0010);
        @(posedge clk) change_notice_pin <= 21'h000008;
        settle(8);
        chk("irq", 1, change_irq);
        rd(3'h7, 16'h0001, "stat");
        @(posedge clk) change_irq_clear <= 1'b1;
        @(posedge clk) change_irq_clear <= 1'b0;
        @(posedge clk) change_notice_pin <= 21'h00000c;
        settle(8);
        chk("irq", 0, change_irq);
        @(posedge clk) change_notice_pin <= 21'h10000c;
        settle(8);
        chk("irq", 1, change_irq);
    endtask : t_change
    task automatic end_of_test;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        fail_count++;
        end_of_test;
    end
    initial begin
        reg_access = '0;
        {change_irq_clear, change_notice_pin} = '0;
        {periph_enable, periph_drive_active, periph_out} = '0;
        ext_en = 16'hffff; // External pull-ups on every pin
        ext_val = 16'hffff;
        t_reset;
        t_latch;
        t_analog;
        t_od;
        t_periph;
        t_change;
        t_reset;
        end_of_test;
    end
endmodule : testbench
